// *** hdl/stpc_power_ctrl.sv ***
// Stop mode power controller with a classic Wishbone register slave
//
// Our own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
// Behaviour
// - Setting the stop request bit to one enters the stop state.
// - Stop halts the main oscillator and main clock; subclock keeps running.
// - Stop halts execution and keeps every register and RAM unchanged.
// - Stop halts all peripherals except those clocked from the subclock or from external clocks; uart_rx stays halted even with uart_ext_baud set.
// - Bus hold requests are not granted while stopped.
// - NMI, an unmasked running-peripheral interrupt, or reset ends stop.
// - Interrupt exit starts the counter; clocks wait for the selected length.
// - After the wait, clocks restart and execution branches to the handler.
// - Reset default of stabilization select gives two to the nineteenth periods.
// - Stop cuts CPU and main-clock peripheral clocks; subclock oscillator continues.
// - Timers four, five and watch count in stop only on subclock.
// - Async serial transmits and clocked serial runs on external clocks.
// - Real-time output runs in stop on timer four/five match if running.
// - Instructions after the store still run before the stop takes hold.
module stpc_power_ctrl #(
  parameter int STAB_CYCLES = stpc_pkg::STAB_RESET_PERIODS
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic nmi_i,
  input wire logic [stpc_pkg::IRQ_W-1:0] periph_irq_i,
  input wire logic bus_hold_request_i,
  input wire logic timer4_active_i,
  input wire logic timer5_active_i,
  output logic main_osc_en_o,
  output logic cpu_clk_en_o,
  output logic subclk_en_o,
  output logic cpu_halt_o,
  output logic bus_hold_ack_o,
  output stpc_pkg::stpc_periph_run_type periph_run_o,
  output logic wake_branch_o,
  output logic [3:0] wake_vector_o
);

  stpc_pkg::stpc_state_type state_r;
  stpc_pkg::stpc_state_type state_nxt;
  stpc_pkg::stpc_periph_cfg_type cfg;
  stpc_pkg::stpc_periph_run_type run_nxt;

  logic ack_r;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic armed_r;
  logic stop_req_r;
  logic stop_req_nxt;
  logic [stpc_pkg::STAB_SEL_W-1:0] stab_sel_r;
  logic [stpc_pkg::IRQ_W-1:0] wake_mask_r;
  logic [stpc_pkg::PER_W-1:0] periph_r;
  logic [stpc_pkg::ENTRY_CNT_W-1:0] entry_cnt_r;
  logic [stpc_pkg::ENTRY_CNT_W-1:0] entry_cnt_nxt;
  logic nmi_meta_r;
  logic nmi_sync_r;
  logic nmi_prev_r;
  logic nmi_pend_r;
  logic hold_meta_r;
  logic hold_sync_r;
  logic last_nmi_r;
  logic [3:0] vector_r;
  logic [3:0] vector_nxt;
  logic branch_r;
  logic osc_en_r;
  logic cpu_en_r;
  logic halt_r;
  logic hold_ack_r;

  // Bus decode: writes land on the edge where ack is seen
  wire access = wb_cyc_i && wb_stb_i;
  wire wr_commit = access && wb_we_i && ack_r;
  wire lane0 = wb_sel_i[0];
  wire hit_protect = (wb_adr_i == stpc_pkg::ADDR_PROTECT);
  wire hit_psc = (wb_adr_i == stpc_pkg::ADDR_PSC);
  wire hit_stab = (wb_adr_i == stpc_pkg::ADDR_STAB);
  wire hit_status = (wb_adr_i == stpc_pkg::ADDR_STATUS);
  wire hit_mask = (wb_adr_i == stpc_pkg::ADDR_WAKE_MASK);
  wire hit_periph = (wb_adr_i == stpc_pkg::ADDR_PERIPH);
  wire psc_write = wr_commit && hit_psc && lane0 && armed_r;
  wire stab_write = wr_commit && hit_stab && lane0;
  wire mask_write = wr_commit && hit_mask && lane0;
  wire periph_write = wr_commit && hit_periph && lane0;
  wire arm_set = wr_commit && hit_protect && lane0;

  // Wake sources
  wire nmi_edge = nmi_sync_r && !nmi_prev_r;
  wire [stpc_pkg::IRQ_W-1:0] irq_live = periph_irq_i & wake_mask_r;
  wire irq_wake = |irq_live;
  wire stopped = (state_r == stpc_pkg::ST_STOPPED);
  wire wake_now = stopped && (nmi_pend_r || irq_wake);
  wire stab_done;
  wire entry_done = (state_r == stpc_pkg::ST_ENTER) && (entry_cnt_r == 4'h0);

  assign cfg = stpc_pkg::stpc_periph_cfg_type'(periph_r);

  // Lowest pending line names the handler; NMI outranks all
  always_comb begin
    vector_nxt = vector_r;
    if (wake_now) begin
      if (nmi_pend_r) begin
        vector_nxt = stpc_pkg::WAKE_CODE_NMI;
      end else begin
        for (int i = stpc_pkg::IRQ_W - 1; i >= 0; i--) begin
          if (irq_live[i]) begin
            vector_nxt = 4'(i);
          end
        end
      end
    end
  end

  // Sequencer
  always_comb begin
    state_nxt = state_r;
    entry_cnt_nxt = entry_cnt_r;
    unique case (state_r)
      stpc_pkg::ST_RUN: begin
        if (psc_write && wb_dat_i[stpc_pkg::PSC_STOP_BIT]) begin
          state_nxt = stpc_pkg::ST_ENTER;
          entry_cnt_nxt = 4'(stpc_pkg::ENTRY_DELAY_CYC - 1);
        end
      end
      stpc_pkg::ST_ENTER: begin
        // Following instructions retire before clocks are pulled
        if (entry_done) begin
          state_nxt = stpc_pkg::ST_STOPPED;
        end else begin
          entry_cnt_nxt = entry_cnt_r - 4'h1;
        end
      end
      stpc_pkg::ST_STOPPED: begin
        if (wake_now) begin
          state_nxt = stpc_pkg::ST_STABILIZE;
        end
      end
      stpc_pkg::ST_STABILIZE: begin
        if (stab_done) begin
          state_nxt = stpc_pkg::ST_RUN;
        end
      end
    endcase
  end

  // Stop bit falls when the device leaves stop
  assign stop_req_nxt = (stab_done && state_r == stpc_pkg::ST_STABILIZE) ? 1'b0 :
                        (psc_write ? wb_dat_i[stpc_pkg::PSC_STOP_BIT] : stop_req_r);

  // Peripheral run enables; the CPU side is assumed on the main clock
  always_comb begin
    run_nxt = '1;
    if (state_nxt == stpc_pkg::ST_STOPPED || state_nxt == stpc_pkg::ST_STABILIZE) begin
      run_nxt.main_periph = 1'b0;
      run_nxt.timer4 = cfg.subclk_present && cfg.tmr4_subclk;
      run_nxt.timer5 = cfg.subclk_present && cfg.tmr5_subclk;
      run_nxt.watch = cfg.subclk_present && cfg.watch_subclk;
      run_nxt.uart_tx = cfg.uart_ext_baud;
      run_nxt.uart_rx = 1'b0;
      run_nxt.csi = cfg.csi_ext_clk;
      run_nxt.rto = cfg.subclk_present && cfg.rto_tm45 &&
                    ((cfg.tmr4_subclk && timer4_active_i) ||
                     (cfg.tmr5_subclk && timer5_active_i));
    end
  end

  // Read mux
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (hit_psc) begin
      rdata_nxt[stpc_pkg::PSC_STOP_BIT] = stop_req_r;
    end else if (hit_stab) begin
      rdata_nxt[stpc_pkg::STAB_SEL_W-1:0] = stab_sel_r;
    end else if (hit_status) begin
      rdata_nxt[1:0] = state_r;
      rdata_nxt[stpc_pkg::STAT_ARMED_BIT] = armed_r;
      rdata_nxt[stpc_pkg::STAT_NMI_BIT] = last_nmi_r;
    end else if (hit_mask) begin
      rdata_nxt[stpc_pkg::IRQ_W-1:0] = wake_mask_r;
    end else if (hit_periph) begin
      rdata_nxt[stpc_pkg::PER_W-1:0] = periph_r;
    end
  end

  stpc_stab_timer u_stab (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .start_i(wake_now),
    .sel_i(stab_sel_r),
    .full_i(stpc_pkg::STAB_CNT_W'(STAB_CYCLES)),
    .done_o(stab_done)
  );

  // Bus slave: one wait state, ack drops the cycle after it rises
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ack_r <= 1'b0;
      rdata_r <= 32'h00000000;
    end else begin
      ack_r <= access && !ack_r;
      rdata_r <= rdata_nxt;
    end
  end

  // Registers; any other write disarms the protection latch
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      armed_r <= 1'b0;
      stop_req_r <= 1'b0;
      stab_sel_r <= stpc_pkg::STAB_SEL_RESET;
      wake_mask_r <= stpc_pkg::WAKE_MASK_RESET;
      periph_r <= stpc_pkg::PERIPH_RESET;
    end else begin
      if (wr_commit) begin
        armed_r <= arm_set;
      end
      stop_req_r <= stop_req_nxt;
      if (stab_write) begin
        stab_sel_r <= wb_dat_i[stpc_pkg::STAB_SEL_W-1:0];
      end
      if (mask_write) begin
        wake_mask_r <= wb_dat_i[stpc_pkg::IRQ_W-1:0];
      end
      if (periph_write) begin
        periph_r <= wb_dat_i[stpc_pkg::PER_W-1:0];
      end
    end
  end

  // Pin synchronisers; the first stage feeds only the second
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nmi_meta_r <= 1'b0;
      nmi_sync_r <= 1'b0;
      nmi_prev_r <= 1'b0;
      hold_meta_r <= 1'b0;
      hold_sync_r <= 1'b0;
    end else begin
      nmi_meta_r <= nmi_i;
      nmi_sync_r <= nmi_meta_r;
      nmi_prev_r <= nmi_sync_r;
      hold_meta_r <= bus_hold_request_i;
      hold_sync_r <= hold_meta_r;
    end
  end

  // NMI edge held until it wakes; a new edge wins over the clear
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      nmi_pend_r <= 1'b0;
      last_nmi_r <= 1'b0;
    end else begin
      nmi_pend_r <= nmi_edge || (nmi_pend_r && !wake_now);
      if (wake_now) begin
        last_nmi_r <= nmi_pend_r;
      end
    end
  end

  // Sequencer and registered outputs
  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= stpc_pkg::ST_RUN;
      entry_cnt_r <= 4'h0;
      vector_r <= 4'h0;
      branch_r <= 1'b0;
      osc_en_r <= 1'b1;
      cpu_en_r <= 1'b1;
      halt_r <= 1'b0;
      hold_ack_r <= 1'b0;
      periph_run_o <= '1;
    end else begin
      state_r <= state_nxt;
      entry_cnt_r <= entry_cnt_nxt;
      vector_r <= vector_nxt;
      branch_r <= (state_r == stpc_pkg::ST_STABILIZE) && stab_done;
      osc_en_r <= (state_nxt != stpc_pkg::ST_STOPPED);
      cpu_en_r <= (state_nxt == stpc_pkg::ST_RUN) || (state_nxt == stpc_pkg::ST_ENTER);
      halt_r <= (state_nxt == stpc_pkg::ST_STOPPED) ||
                (state_nxt == stpc_pkg::ST_STABILIZE);
      hold_ack_r <= hold_sync_r && (state_nxt == stpc_pkg::ST_RUN);
      periph_run_o <= run_nxt;
    end
  end

  // Subclock distribution is never gated by this block
  assign subclk_en_o = 1'b1;
  assign main_osc_en_o = osc_en_r;
  assign cpu_clk_en_o = cpu_en_r;
  assign cpu_halt_o = halt_r;
  assign bus_hold_ack_o = hold_ack_r;
  assign wake_branch_o = branch_r;
  assign wake_vector_o = vector_r;
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rdata_r;

endmodule // stpc_power_ctrl

// *** hdl/stpc_pkg.sv ***
// Constants and types for the stop mode power controller
package stpc_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] ADDR_PROTECT = 8'h00;
  localparam logic [7:0] ADDR_PSC = 8'h04;
  localparam logic [7:0] ADDR_STAB = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_WAKE_MASK = 8'h10;
  localparam logic [7:0] ADDR_PERIPH = 8'h14;

  // Field positions
  localparam int PSC_STOP_BIT = 1;
  localparam int PER_SUBCLK_PRESENT = 0;
  localparam int PER_TMR4_SUBCLK = 1;
  localparam int PER_TMR5_SUBCLK = 2;
  localparam int PER_WATCH_SUBCLK = 3;
  localparam int PER_UART_EXT_BAUD = 4;
  localparam int PER_CSI_EXT_CLK = 5;
  localparam int PER_RTO_TM45 = 6;
  localparam int STAT_ARMED_BIT = 2;
  localparam int STAT_NMI_BIT = 3;

  // Widths and reset values
  localparam int IRQ_W = 8;
  localparam int PER_W = 7;
  localparam int STAB_SEL_W = 3;
  localparam int STAB_CNT_W = 20;
  localparam logic [STAB_SEL_W-1:0] STAB_SEL_RESET = 3'h4;
  localparam logic [IRQ_W-1:0] WAKE_MASK_RESET = 8'h00;
  localparam logic [PER_W-1:0] PERIPH_RESET = 7'h00;

  // Stabilization lengths, as right shifts of the longest count
  localparam int STAB_RESET_PERIODS = 524288;
  localparam logic [4:0] STAB_SHIFT_0 = 5'h06;
  localparam logic [4:0] STAB_SHIFT_1 = 5'h04;
  localparam logic [4:0] STAB_SHIFT_2 = 5'h02;
  localparam logic [4:0] STAB_SHIFT_3 = 5'h01;
  localparam logic [4:0] STAB_SHIFT_4 = 5'h00;

  // Entry delay lets the instructions after the store retire
  localparam int MAIN_CLK_PERIOD_NS = 8;
  localparam int ENTRY_DELAY_NS = 64;
  localparam int ENTRY_DELAY_CYC = (ENTRY_DELAY_NS + MAIN_CLK_PERIOD_NS - 1) / MAIN_CLK_PERIOD_NS;
  localparam int ENTRY_CNT_W = 4;

  localparam logic [3:0] WAKE_CODE_NMI = 4'hF;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_ENTER,
    ST_STOPPED,
    ST_STABILIZE
  } stpc_state_type;

  typedef struct packed {
    logic rto_tm45;
    logic csi_ext_clk;
    logic uart_ext_baud;
    logic watch_subclk;
    logic tmr5_subclk;
    logic tmr4_subclk;
    logic subclk_present;
  } stpc_periph_cfg_type;

  typedef struct packed {
    logic main_periph;
    logic timer4;
    logic timer5;
    logic watch;
    logic uart_tx;
    logic uart_rx;
    logic csi;
    logic rto;
  } stpc_periph_run_type;

endpackage

// *** hdl/stpc_stab_timer.sv ***
// Oscillation stabilization counter, watchdog style
`timescale 1ns/1ps
module stpc_stab_timer (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic start_i,
  input wire logic [stpc_pkg::STAB_SEL_W-1:0] sel_i,
  input wire logic [stpc_pkg::STAB_CNT_W-1:0] full_i,
  output logic done_o
);

  logic [stpc_pkg::STAB_CNT_W-1:0] cnt_r;
  logic [stpc_pkg::STAB_CNT_W-1:0] cnt_nxt;
  logic busy_r;
  logic busy_nxt;
  logic [4:0] shift;
  logic [stpc_pkg::STAB_CNT_W-1:0] scaled;
  logic [stpc_pkg::STAB_CNT_W-1:0] load;

  // Codes above the top select fall back to the longest wait
  assign shift = (sel_i == 3'h0) ? stpc_pkg::STAB_SHIFT_0 :
                 (sel_i == 3'h1) ? stpc_pkg::STAB_SHIFT_1 :
                 (sel_i == 3'h2) ? stpc_pkg::STAB_SHIFT_2 :
                 (sel_i == 3'h3) ? stpc_pkg::STAB_SHIFT_3 : stpc_pkg::STAB_SHIFT_4;
  assign scaled = full_i >> shift;
  // Never less than one cycle, even for a shortened simulation count
  assign load = (scaled == 20'h00000) ? 20'h00001 : scaled;
  assign done_o = busy_r && (cnt_r == 20'h00001);

  assign busy_nxt = start_i ? 1'b1 : (done_o ? 1'b0 : busy_r);
  assign cnt_nxt = start_i ? load : (busy_r ? cnt_r - 20'h00001 : cnt_r);

  always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_r <= 20'h00000;
      busy_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
    end
  end

endmodule // stpc_stab_timer

// *** tb/stpc_power_ctrl_checker.sv ***
// Port assertions for the stop mode power controller
`timescale 1ns/1ps
module stpc_power_ctrl_checker #(
  parameter int STAB_CYCLES = 64
) (
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic main_osc_en_o,
  input wire logic cpu_clk_en_o,
  input wire logic subclk_en_o,
  input wire logic cpu_halt_o,
  input wire logic bus_hold_ack_o,
  input stpc_pkg::stpc_periph_run_type periph_run_o,
  input wire logic wake_branch_o
);
  // Slack covers the output registers; the nmi synchronizer acts before s_stab
  localparam int WAIT_MAX = STAB_CYCLES + 8;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_stab;
    $rose(main_osc_en_o);
  endsequence
  sequence s_wake;
    $fell(cpu_halt_o);
  endsequence
  a_osc_off_halt: assert property (!main_osc_en_o |-> cpu_halt_o && !cpu_clk_en_o)
    else $error("cpu clock live while oscillator off");
  a_subclk_runs: assert property (subclk_en_o)
    else $error("subclock stopped");
  a_hold_refused: assert property (cpu_halt_o |-> !bus_hold_ack_o)
    else $error("bus hold granted while stopped");
  a_stab_gate: assert property (s_stab |-> cpu_halt_o && !cpu_clk_en_o)
    else $error("clock back before stabilization");
  a_stab_wait: assert property (s_stab |-> ##[1:WAIT_MAX] s_wake)
    else $error("stabilization never ended");
  a_wake_branch: assert property (s_wake |-> ##[0:1] wake_branch_o)
    else $error("no branch at wake");
  a_branch_run: assert property (wake_branch_o |-> cpu_clk_en_o && main_osc_en_o && !cpu_halt_o)
    else $error("branch while clocks off");
  a_branch_pulse: assert property (wake_branch_o |=> !wake_branch_o)
    else $error("branch pulse too long");
  a_periph_stop: assert property (!main_osc_en_o |-> !periph_run_o.main_periph && !periph_run_o.uart_rx)
    else $error("main peripheral running in stop");
  a_periph_run: assert property (!cpu_halt_o |-> periph_run_o == 8'hFF)
    else $error("peripheral halted outside stop");
  a_entry_order: assert property ($fell(cpu_clk_en_o) |-> $fell(main_osc_en_o))
    else $error("cpu clock and oscillator out of step");
  c_stab: cover property (s_stab ##[1:WAIT_MAX] s_wake);
endmodule // stpc_power_ctrl_checker

bind stpc_power_ctrl stpc_power_ctrl_checker #(.STAB_CYCLES(STAB_CYCLES)) u_chk (.ref_clk_i,
  .reset_n_i, .main_osc_en_o, .cpu_clk_en_o, .subclk_en_o, .cpu_halt_o, .bus_hold_ack_o,
  .periph_run_o, .wake_branch_o);

// *** tb/stpc_cpu_model.sv ***
// CPU software model driving the register bus
`timescale 1ns/1ps
module stpc_cpu_model (
  input wire logic ref_clk_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_i,
  output logic wb_cyc_o,
  output logic wb_stb_o,
  output logic wb_we_o,
  output logic [7:0] wb_adr_o,
  output logic [3:0] wb_sel_o,
  output logic [31:0] wb_dat_o
);
  int seed = 32'hf70d;
  initial begin
    {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} = '0;
  end
  task automatic acc(input logic we, input logic [7:0] adr, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    {wb_cyc_o, wb_stb_o, wb_we_o, wb_adr_o, wb_sel_o, wb_dat_o} <= {2'b11, we, adr, 4'hF, d};
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (wb_ack_i !== 1'b1 && n < 50);
    q = wb_dat_i;
    {wb_cyc_o, wb_stb_o} <= 2'b00;
    // Released lines carry junk, not the old value
    wb_adr_o <= ~adr;
    wb_dat_o <= ~d;
    @(posedge ref_clk_i);
    if (n >= 50) tb_stpc_power_ctrl.hang();
  endtask
  task automatic enter_stop(input logic [7:0] ps);
    logic [31:0] q;
    // Dma off and interrupt block flag set before this point
    acc(1'b1, stpc_pkg::ADDR_PROTECT, {24'h0, 8'($random(seed))}, q);
    acc(1'b1, stpc_pkg::ADDR_PSC, {24'h0, ps}, q);
    // Unblock, then two padding no-ops; internal fetch only
    repeat (2) @(posedge ref_clk_i);
  endtask
endmodule // stpc_cpu_model

// *** tb/tb_stpc_power_ctrl.sv ***
// Self-checking bench for the stop mode power controller
`timescale 1ns/1ps
module tb_stpc_power_ctrl;
  localparam int STAB = 64;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic nmi = 1'b0, hold_req = 1'b0, t4 = 1'b0, t5 = 1'b0;
  logic wb_cyc, wb_stb, wb_we, wb_ack, osc, cpu_en, halt, hold_ack, subclk, branch;
  logic [7:0] wb_adr, cfg, mask, pend;
  logic [7:0] irq = 8'h00;
  logic [3:0] wb_sel, vec;
  logic [31:0] wb_dat_w, wb_dat_r, q;
  stpc_pkg::stpc_periph_run_type prun;
  int error_cnt = 0, compares = 0, seed = 32'hf70d, n, len;
  always #4 ref_clk_i = ~ref_clk_i;
  stpc_cpu_model cpu (.ref_clk_i(ref_clk_i), .wb_dat_i(wb_dat_r), .wb_ack_i(wb_ack),
    .wb_cyc_o(wb_cyc), .wb_stb_o(wb_stb), .wb_we_o(wb_we), .wb_adr_o(wb_adr),
    .wb_sel_o(wb_sel), .wb_dat_o(wb_dat_w));
  stpc_power_ctrl #(.STAB_CYCLES(STAB)) dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack),
    .nmi_i(nmi), .periph_irq_i(irq), .bus_hold_request_i(hold_req), .timer4_active_i(t4),
    .timer5_active_i(t5), .main_osc_en_o(osc), .cpu_clk_en_o(cpu_en), .subclk_en_o(subclk),
    .cpu_halt_o(halt), .bus_hold_ack_o(hold_ack), .periph_run_o(prun),
    .wake_branch_o(branch), .wake_vector_o(vec));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic hang;
    error_cnt++;
    $display("[ERR] %0t wait ran out", $time);
    stop_test();
  endtask
  // Bounded wait on the halt level, counted in falling edges
  task automatic wait_halt(input logic lvl, output int c);
    c = 0;
    while (halt !== lvl) begin
      @(negedge ref_clk_i);
      c++;
      if (c > 200) hang();
    end
  endtask
  function automatic int stab_len(input logic [2:0] s);
    int sh;
    sh = (s == 0) ? 6 : (s == 1) ? 4 : (s == 2) ? 2 : (s == 3) ? 1 : 0;
    return ((STAB >> sh) > 1) ? (STAB >> sh) : 1;
  endfunction
  function automatic logic [7:0] stop_run(input logic [6:0] c, input logic a4, input logic a5);
    return {1'b0, c[0] & c[1], c[0] & c[2], c[0] & c[3], c[4], 1'b0, c[5],
            c[0] & c[6] & ((c[1] & a4) | (c[2] & a5))};
  endfunction
  function automatic logic [3:0] low_idx(input logic [7:0] v);
    low_idx = 4'h0;
    for (int b = 7; b >= 0; b--) if (v[b]) low_idx = 4'(b);
  endfunction
  initial begin
    repeat (4) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    cpu.acc(1'b0, stpc_pkg::ADDR_STAB, 32'h0, q);
    chk(q, 32'h4);
    cpu.acc(1'b0, 8'h3C, 32'h0, q);
    chk(q, 32'h0);
    cpu.acc(1'b1, stpc_pkg::ADDR_PSC, 32'h2, q);
    cpu.acc(1'b1, stpc_pkg::ADDR_PROTECT, 32'h5A, q);
    cpu.acc(1'b1, stpc_pkg::ADDR_STAB, 32'h4, q);
    cpu.acc(1'b1, stpc_pkg::ADDR_PSC, 32'h2, q);
    cpu.acc(1'b0, stpc_pkg::ADDR_PSC, 32'h0, q);
    chk(q, 32'h0);
    chk(halt, 1'b0);
    hold_req <= 1'b1;
    repeat (5) @(posedge ref_clk_i);
    chk(hold_ack, 1'b1);
    // Last pass uses an out-of-range select and the nmi as waker
    for (int i = 0; i < 6; i++) begin
      cfg = 8'($random(seed));
      mask = 8'($random(seed)) | 8'h01;
      pend = mask & 8'($random(seed));
      if (pend == 8'h00) pend = mask;
      {t4, t5} <= 2'($random(seed));
      cpu.acc(1'b1, stpc_pkg::ADDR_STAB, (i == 5) ? 32'h7 : 32'(i), q);
      cpu.acc(1'b1, stpc_pkg::ADDR_PERIPH, {24'h0, cfg}, q);
      cpu.acc(1'b1, stpc_pkg::ADDR_WAKE_MASK, {24'h0, mask}, q);
      chk(cpu_en, 1'b1);
      cpu.enter_stop(8'h02);
      wait_halt(1'b1, n);
      chk(n, stpc_pkg::ENTRY_DELAY_CYC - 2);
      chk(osc, 1'b0);
      chk(subclk, 1'b1);
      chk(prun, stop_run(cfg[6:0], t4, t5));
      chk(hold_ack, 1'b0);
      @(posedge ref_clk_i);
      irq <= ~mask;
      repeat (6) @(posedge ref_clk_i);
      chk(halt, 1'b1);
      if (i == 5) nmi <= 1'b1;
      else irq <= ~mask | pend;
      len = stab_len((i == 5) ? 3'h7 : 3'(i));
      wait_halt(1'b0, n);
      chk(n >= len + 1 && n <= len + 5, 1'b1);
      chk(branch, 1'b1);
      @(posedge ref_clk_i);
      irq <= 8'h00;
      nmi <= 1'b0;
      chk(vec, (i == 5) ? 4'hF : low_idx(pend));
      cpu.acc(1'b0, stpc_pkg::ADDR_PSC, 32'h0, q);
      chk(q, 32'h0);
      cpu.acc(1'b0, stpc_pkg::ADDR_STATUS, 32'h0, q);
      chk(q[3], i == 5);
      cpu.acc(1'b0, stpc_pkg::ADDR_WAKE_MASK, 32'h0, q);
      chk(q, {24'h0, mask});
    end
    cpu.enter_stop(8'h02);
    wait_halt(1'b1, n);
    @(posedge ref_clk_i);
    reset_n_i <= 1'b0;
    @(negedge ref_clk_i);
    chk({osc, halt}, 2'b10);
    @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(posedge ref_clk_i);
    cpu.acc(1'b0, stpc_pkg::ADDR_PSC, 32'h0, q);
    chk(q, 32'h0);
    stop_test();
  end
endmodule // tb_stpc_power_ctrl
